// ===== core/port_ctl_consts.svh
// constants for the quad port controller core: offsets, reset values, timing
// assumes a single 20 MHz system clock; all times converted in the core
`ifndef PORT_CTL_CONSTS_SVH
`define PORT_CTL_CONSTS_SVH

// system clock rate in hertz
`define MCLK_HZ 20000000

// downstream scl targets, hertz
`define DS_SCL_STD_HZ 83000
`define DS_SCL_FAST_HZ 332000

// downstream bus free time, microseconds
`define DS_BUF_US 20

// downstream spike width suppressed, nanoseconds
`define DS_SPIKE_NS 50

// strap level selecting the i2c host port
`define STRAP_I2C 1'b1

// command word layout: [15:12] opcode, [11:8] flags, [7:0] data
`define CMD_OP_MSB 15
`define CMD_OP_LSB 12
`define CMD_FLAG_START 8
`define CMD_FLAG_STOP 9
`define CMD_FLAG_FAST 10
`define CMD_DATA_MSB 7

// opcodes
`define OP_LED_C 4'h1
`define OP_LED_D 4'h2
`define OP_DS_WR 4'h3

// led reset and run levels
`define LED_OFF 1'b1
`define LED_OE_RESET 1'b0
`define LED_OE_RUN 1'b1

`endif

// ===== core/port_ctl_pkg.sv
// types shared by the quad port controller core
// assumes the constants header supplies all numeric values
package port_ctl_pkg;

    // downstream i2c master states, one-hot
    typedef enum logic [8:0] {
        DS_IDLE    = 9'h001,
        DS_GAP     = 9'h002,
        DS_RS_LO   = 9'h004,
        DS_RS_HI   = 9'h008,
        DS_START   = 9'h010,
        DS_LOW     = 9'h020,
        DS_HIGH    = 9'h040,
        DS_STOP_LO = 9'h080,
        DS_STOP_HI = 9'h100
    } ds_state_t;

endpackage

// ===== core/sync_filter.sv
// two-flop synchroniser plus spike filter, one lane per input bit
// assumes inputs are asynchronous pins; output idles at the synced level
`timescale 1ns/100ps
module sync_filter #(
    parameter int WIDTH = 1,
    parameter int STABLE = 3
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] filt_o
);
    localparam int CW = $clog2(STABLE + 1);

    if (WIDTH < 1 || STABLE < 1) begin : g_bad_param
        $error("sync_filter: WIDTH and STABLE must be at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        logic meta_q;
        logic sync_q;
        logic filt_q;
        logic [CW-1:0] cnt_q;

        // two-flop synchroniser
        always_ff @(posedge mclk_i) begin
            meta_q <= pin_i[i];
            sync_q <= meta_q;
        end

        // accept a new level only after STABLE equal samples
        always_ff @(posedge mclk_i) begin
            if (rst_i) begin
                cnt_q <= '0;
                filt_q <= sync_q;
            end else if (sync_q == filt_q) begin
                cnt_q <= '0;
            end else if (cnt_q == CW'(STABLE - 1)) begin
                cnt_q <= '0;
                filt_q <= sync_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end

        assign filt_o[i] = filt_q;
    end
endmodule

// ===== core/port_ctl_top.sv
// quad port controller core: strap-selected host port, led drive, downstream i2c master
// assumes mclk_i at 20 MHz, spi_sclk_i from the host, open-drain pads resolved outside
`timescale 1ns/100ps
`include "port_ctl_consts.svh"
module port_ctl_top
    import port_ctl_pkg::*;
#(
    parameter int NPORTS = 4,
    parameter logic [6:0] HOST_ADDR = 7'h2a // arbitrary default target address
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic protocol_sel_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    input wire logic host_scl_i,
    input wire logic host_sda_i,
    output logic host_sda_o,
    output logic host_sda_oe_o,
    output logic [NPORTS-1:0] led_c_o,
    output logic [NPORTS-1:0] led_c_oe_o,
    output logic [NPORTS-1:0] led_d_o,
    output logic [NPORTS-1:0] led_d_oe_o,
    input wire logic ds_scl_i,
    output logic ds_scl_o,
    output logic ds_scl_oe_o,
    input wire logic ds_sda_i,
    output logic ds_sda_o,
    output logic ds_sda_oe_o,
    output logic host_is_i2c_o,
    output logic ds_busy_o,
    output logic ds_nack_o
);
    localparam int MCLK_NS = 1000000000 / `MCLK_HZ;
    localparam int HALF_STD = `MCLK_HZ / (2 * `DS_SCL_STD_HZ);
    localparam int HALF_FAST = `MCLK_HZ / (2 * `DS_SCL_FAST_HZ);
    localparam int BUF_CYC = (`DS_BUF_US * 1000 + MCLK_NS - 1) / MCLK_NS;
    localparam int SPIKE_CYC = (`DS_SPIKE_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int CNTW = $clog2(BUF_CYC + 1);

    if (NPORTS < 1 || NPORTS > 8) begin : g_bad_ports
        $error("port_ctl_top: NPORTS must be 1 to 8");
    end
    if (HALF_FAST < 2 || HALF_STD >= BUF_CYC) begin : g_bad_timing
        $error("port_ctl_top: clock rate cannot serve downstream timing");
    end

    // ---------------- pin synchronisers and filters ----------------
    logic [5:0] pins_f;
    logic ds_scl_f;
    logic ds_sda_f;
    logic h_scl_f;
    logic h_sda_f;
    logic en_f;
    logic strap_f;

    sync_filter #(
        .WIDTH(6),
        .STABLE(SPIKE_CYC + 2)
    ) u_pins (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .pin_i({protocol_sel_i, en_i, host_sda_i, host_scl_i, ds_sda_i, ds_scl_i}),
        .filt_o(pins_f)
    );

    assign ds_scl_f = pins_f[0];
    assign ds_sda_f = pins_f[1];
    assign h_scl_f = pins_f[2];
    assign h_sda_f = pins_f[3];
    assign en_f = pins_f[4];
    assign strap_f = pins_f[5];

    logic dev_rst;
    assign dev_rst = rst_i | ~en_f;

    logic zero_q;
    always_ff @(posedge mclk_i) begin
        zero_q <= 1'b0;
    end
    assign host_sda_o = zero_q;
    assign ds_scl_o = zero_q;
    assign ds_sda_o = zero_q;

    // ---------------- protocol strap ----------------
    logic strap_done_q;
    logic is_i2c_q;

    always_ff @(posedge mclk_i) begin
        if (dev_rst) begin
            strap_done_q <= 1'b0;
            is_i2c_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            is_i2c_q <= (strap_f == `STRAP_I2C);
        end
    end
    assign host_is_i2c_o = is_i2c_q;

    // ---------------- spi target, link clock domain ----------------
    logic [3:0] spi_cnt_q;
    logic [15:0] spi_sh_q;
    logic [15:0] spi_word_q;
    logic spi_tgl_q;

    // bit counter restarts with each frame
    always_ff @(posedge spi_sclk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            spi_cnt_q <= '0;
        end else begin
            spi_cnt_q <= spi_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge spi_sclk_i) begin
        spi_sh_q <= {spi_sh_q[14:0], spi_mosi_i};
    end

    // every sixteenth bit hands a word over
    always_ff @(posedge spi_sclk_i or posedge rst_i) begin
        if (rst_i) begin
            spi_word_q <= '0;
            spi_tgl_q <= 1'b0;
        end else if (!spi_cs_n_i && spi_cnt_q == 4'hf) begin
            spi_word_q <= {spi_sh_q[14:0], spi_mosi_i};
            spi_tgl_q <= ~spi_tgl_q;
        end
    end

    // toggle crossing into mclk
    logic tgl_m1_q;
    logic tgl_m2_q;
    logic tgl_m3_q;
    logic spi_evt;

    always_ff @(posedge mclk_i) begin
        tgl_m1_q <= spi_tgl_q;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            tgl_m2_q <= 1'b0;
            tgl_m3_q <= 1'b0;
        end else begin
            tgl_m2_q <= tgl_m1_q;
            tgl_m3_q <= tgl_m2_q;
        end
    end
    assign spi_evt = tgl_m2_q ^ tgl_m3_q;

    // ---------------- i2c target on host side ----------------
    logic h_scl_p_q;
    logic h_sda_p_q;
    logic h_start;
    logic h_stop;
    logic h_rise;
    logic h_fall;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            h_scl_p_q <= 1'b1;
            h_sda_p_q <= 1'b1;
        end else begin
            h_scl_p_q <= h_scl_f;
            h_sda_p_q <= h_sda_f;
        end
    end
    assign h_start = h_scl_f & h_scl_p_q & h_sda_p_q & ~h_sda_f;
    assign h_stop = h_scl_f & h_scl_p_q & ~h_sda_p_q & h_sda_f;
    assign h_rise = h_scl_f & ~h_scl_p_q;
    assign h_fall = ~h_scl_f & h_scl_p_q;

    logic t_live_q;
    logic t_ack_q;
    logic [3:0] t_bit_q;
    logic [1:0] t_byte_q;
    logic [7:0] t_sh_q;
    logic [7:0] t_cmd_q;
    logic [15:0] t_word_q;
    logic t_evt_q;

    // write-only target, address then command pairs
    always_ff @(posedge mclk_i) begin
        t_evt_q <= 1'b0;
        if (dev_rst || !is_i2c_q || h_stop) begin
            t_live_q <= 1'b0;
            t_ack_q <= 1'b0;
            t_bit_q <= '0;
            t_byte_q <= '0;
        end else if (h_start) begin
            t_live_q <= 1'b1;
            t_ack_q <= 1'b0;
            t_bit_q <= '0;
            t_byte_q <= '0;
        end else if (t_live_q) begin
            if (h_rise && !t_ack_q) begin
                t_sh_q <= {t_sh_q[6:0], h_sda_f};
                t_bit_q <= t_bit_q + 1'b1;
            end else if (h_fall && t_ack_q) begin
                t_ack_q <= 1'b0;
                t_bit_q <= '0;
            end else if (h_fall && t_bit_q == 4'h8) begin
                if (t_byte_q == 2'h0) begin
                    if (t_sh_q == {HOST_ADDR, 1'b0}) begin
                        t_ack_q <= 1'b1;
                        t_byte_q <= 2'h1;
                    end else begin
                        t_live_q <= 1'b0;
                    end
                end else if (t_byte_q == 2'h1) begin
                    t_cmd_q <= t_sh_q;
                    t_ack_q <= 1'b1;
                    t_byte_q <= 2'h2;
                end else begin
                    t_word_q <= {t_cmd_q, t_sh_q};
                    t_evt_q <= 1'b1;
                    t_ack_q <= 1'b1;
                    t_byte_q <= 2'h1;
                end
            end
        end
    end
    assign host_sda_oe_o = t_ack_q;

    // ---------------- command select ----------------
    logic cmd_evt;
    logic [15:0] cmd_word;
    logic [3:0] cmd_op;

    // only the strapped port issues commands
    assign cmd_evt = strap_done_q & (is_i2c_q ? t_evt_q : spi_evt);
    assign cmd_word = is_i2c_q ? t_word_q : spi_word_q;
    assign cmd_op = cmd_word[`CMD_OP_MSB:`CMD_OP_LSB];

    // ---------------- led drive ----------------
    logic [NPORTS-1:0] led_c_q;
    logic [NPORTS-1:0] led_d_q;
    logic [NPORTS-1:0] led_oe_q;

    always_ff @(posedge mclk_i) begin
        if (dev_rst) begin
            led_c_q <= {NPORTS{`LED_OFF}};
            led_d_q <= {NPORTS{`LED_OFF}};
            led_oe_q <= {NPORTS{`LED_OE_RESET}};
        end else begin
            led_oe_q <= {NPORTS{`LED_OE_RUN}};
            // a set bit lights, pin low
            if (cmd_evt && cmd_op == `OP_LED_C) begin
                led_c_q <= ~cmd_word[NPORTS-1:0];
            end
            if (cmd_evt && cmd_op == `OP_LED_D) begin
                led_d_q <= ~cmd_word[NPORTS-1:0];
            end
        end
    end

    assign led_c_o = led_c_q;
    assign led_d_o = led_d_q;
    assign led_c_oe_o = led_oe_q;
    assign led_d_oe_o = led_oe_q;

    // ---------------- downstream i2c master ----------------
    ds_state_t ds_st_q;
    logic [CNTW-1:0] ds_cnt_q;
    logic [7:0] ds_sh_q;
    logic [3:0] ds_bit_q;
    logic ds_stop_q;
    logic ds_fast_q;
    logic ds_held_q;
    logic ds_scl_oe_q;
    logic ds_sda_oe_q;
    logic ds_nack_q;
    logic ds_busy_q;
    logic ds_go;
    logic half_done;

    assign ds_go = cmd_evt && cmd_op == `OP_DS_WR && ds_st_q == DS_IDLE;
    assign half_done = ds_fast_q ? (ds_cnt_q == CNTW'(HALF_FAST - 1))
                                 : (ds_cnt_q == CNTW'(HALF_STD - 1));

    always_ff @(posedge mclk_i) begin
        if (dev_rst) begin
            ds_st_q <= DS_IDLE;
            ds_cnt_q <= '0;
            ds_sh_q <= '0;
            ds_bit_q <= '0;
            ds_stop_q <= 1'b0;
            ds_fast_q <= 1'b0;
            ds_held_q <= 1'b0;
            ds_scl_oe_q <= 1'b0;
            ds_sda_oe_q <= 1'b0;
            ds_nack_q <= 1'b0;
        end else begin
            // counts only while scl is driven low or seen high
            if (ds_scl_oe_q || ds_scl_f) begin
                ds_cnt_q <= ds_cnt_q + 1'b1;
            end
            unique case (ds_st_q)
                DS_IDLE: begin
                    ds_cnt_q <= '0;
                    if (ds_go) begin
                        ds_sh_q <= cmd_word[`CMD_DATA_MSB:0];
                        ds_stop_q <= cmd_word[`CMD_FLAG_STOP];
                        ds_fast_q <= cmd_word[`CMD_FLAG_FAST];
                        ds_nack_q <= 1'b0;
                        ds_bit_q <= '0;
                        if (ds_held_q && cmd_word[`CMD_FLAG_START]) begin
                            ds_sda_oe_q <= 1'b0;
                            ds_st_q <= DS_RS_LO;
                        end else if (ds_held_q) begin
                            ds_sda_oe_q <= ~cmd_word[`CMD_DATA_MSB];
                            ds_st_q <= DS_LOW;
                        end else begin
                            ds_sda_oe_q <= 1'b1;
                            ds_st_q <= DS_START;
                        end
                    end
                end
                DS_GAP: begin
                    // bus free after a stop, scl held low after a byte without stop, before any new command
                    if (ds_cnt_q == CNTW'(BUF_CYC - 1)) begin
                        ds_st_q <= DS_IDLE;
                    end
                end
                DS_RS_LO: begin
                    if (half_done) begin
                        ds_scl_oe_q <= 1'b0;
                        ds_cnt_q <= '0;
                        ds_st_q <= DS_RS_HI;
                    end
                end
                DS_RS_HI: begin
                    if (half_done) begin
                        ds_sda_oe_q <= 1'b1;
                        ds_cnt_q <= '0;
                        ds_st_q <= DS_START;
                    end
                end
                DS_START: begin
                    if (half_done) begin
                        ds_scl_oe_q <= 1'b1;
                        ds_sda_oe_q <= ~ds_sh_q[7];
                        ds_cnt_q <= '0;
                        ds_st_q <= DS_LOW;
                    end
                end
                DS_LOW: begin
                    if (half_done) begin
                        ds_scl_oe_q <= 1'b0;
                        ds_cnt_q <= '0;
                        ds_st_q <= DS_HIGH;
                    end
                end
                DS_HIGH: begin
                    if (half_done) begin
                        ds_scl_oe_q <= 1'b1;
                        ds_cnt_q <= '0;
                        if (ds_bit_q == 4'h8) begin
                            ds_nack_q <= ds_sda_f;
                            if (ds_stop_q) begin
                                ds_sda_oe_q <= 1'b1;
                                ds_st_q <= DS_STOP_LO;
                            end else begin
                                ds_held_q <= 1'b1;
                                ds_sda_oe_q <= 1'b0;
                                ds_st_q <= DS_GAP;
                            end
                        end else begin
                            ds_bit_q <= ds_bit_q + 1'b1;
                            ds_sh_q <= {ds_sh_q[6:0], 1'b0};
                            ds_sda_oe_q <= (ds_bit_q == 4'h7) ? 1'b0 : ~ds_sh_q[6];
                            ds_st_q <= DS_LOW;
                        end
                    end
                end
                DS_STOP_LO: begin
                    if (half_done) begin
                        ds_scl_oe_q <= 1'b0;
                        ds_cnt_q <= '0;
                        ds_st_q <= DS_STOP_HI;
                    end
                end
                DS_STOP_HI: begin
                    if (half_done) begin
                        ds_sda_oe_q <= 1'b0;
                        ds_held_q <= 1'b0;
                        ds_cnt_q <= '0;
                        ds_st_q <= DS_GAP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (dev_rst) begin
            ds_busy_q <= 1'b0;
        end else begin
            ds_busy_q <= (ds_st_q != DS_IDLE) || ds_go;
        end
    end

    assign ds_scl_oe_o = ds_scl_oe_q;
    assign ds_sda_oe_o = ds_sda_oe_q;
    assign ds_nack_o = ds_nack_q;
    assign ds_busy_o = ds_busy_q;
endmodule

// ===== tb/port_ctl_top_monitor.sv
// checker for the port controller top-level ports
// assumes binding into port_ctl_top, all watched logic on mclk_i
`timescale 1ns/100ps
module port_ctl_top_monitor #(
    parameter int NPORTS = 4
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic protocol_sel_i,
    input wire logic host_sda_oe_o,
    input wire logic [NPORTS-1:0] led_c_o,
    input wire logic [NPORTS-1:0] led_c_oe_o,
    input wire logic [NPORTS-1:0] led_d_o,
    input wire logic [NPORTS-1:0] led_d_oe_o,
    input wire logic ds_scl_oe_o,
    input wire logic ds_sda_oe_o,
    input wire logic host_is_i2c_o,
    input wire logic ds_busy_o
);
    logic [3:0] run_q;
    logic [9:0] gap_q;
    logic [9:0] ph_q;

    // cycles since reset or enable low
    always_ff @(posedge mclk_i) begin
        if (rst_i || !en_i) begin
            run_q <= 4'h0;
        end else if (run_q != 4'hf) begin
            run_q <= run_q + 4'h1;
        end
    end

    // cycles since any downstream line moved
    always_ff @(posedge mclk_i) begin
        if (rst_i || $changed(ds_scl_oe_o) || $changed(ds_sda_oe_o)) begin
            gap_q <= 10'h000;
        end else if (gap_q != 10'h3ff) begin
            gap_q <= gap_q + 10'h001;
        end
    end

    // cycles since scl moved
    always_ff @(posedge mclk_i) begin
        if (rst_i || $changed(ds_scl_oe_o)) begin
            ph_q <= 10'h000;
        end else if (ph_q != 10'h3ff) begin
            ph_q <= ph_q + 10'h001;
        end
    end

    chk_reset_tristate: assert property (@(posedge mclk_i) rst_i |=> led_c_oe_o == '0 && led_d_oe_o == '0)
        else $error("led outputs driven during reset");
    chk_release_leds_off: assert property (@(posedge mclk_i) $fell(rst_i) && en_i |=>
        led_c_oe_o == '1 && led_d_oe_o == '1 && led_c_o == '1 && led_d_o == '1)
        else $error("leds not enabled and off after release");
    chk_strap_capture: assert property (@(posedge mclk_i) $fell(rst_i) && en_i |=>
        host_is_i2c_o == $past(protocol_sel_i))
        else $error("strap not captured at release");
    chk_run_steady: assert property (@(posedge mclk_i) disable iff (rst_i) run_q == 4'hf |->
        led_c_oe_o == '1 && led_d_oe_o == '1 && $stable(host_is_i2c_o))
        else $error("led enable or host mode moved in normal run");
    chk_enable_tristate: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(en_i) |-> ##[1:10] (led_c_oe_o == '0 && led_d_oe_o == '0))
        else $error("leds still driven after enable low");
    chk_group_enable: assert property (@(posedge mclk_i) disable iff (rst_i)
        led_c_oe_o == led_d_oe_o && (led_c_oe_o == '0 || led_c_oe_o == '1))
        else $error("led groups enabled unevenly");
    chk_host_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
        !host_is_i2c_o |-> !host_sda_oe_o)
        else $error("i2c host port active in spi mode");
    chk_scl_low_min: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(ds_scl_oe_o) |-> ph_q >= 10'd25)
        else $error("downstream scl low phase too short");
    chk_scl_high_min: assert property (@(posedge mclk_i) disable iff (rst_i)
        $rose(ds_scl_oe_o) && ds_busy_o |-> ph_q >= 10'd11)
        else $error("downstream scl high phase too short");
    chk_bus_free_gap: assert property (@(posedge mclk_i) disable iff (rst_i)
        $fell(ds_busy_o) |-> gap_q >= 10'd395)
        else $error("downstream bus free time too short");
endmodule

bind port_ctl_top port_ctl_top_monitor #(.NPORTS(NPORTS)) i_port_ctl_top_monitor (
    .mclk_i, .rst_i, .en_i, .protocol_sel_i, .host_sda_oe_o, .led_c_o, .led_c_oe_o, .led_d_o,
    .led_d_oe_o, .ds_scl_oe_o, .ds_sda_oe_o, .host_is_i2c_o, .ds_busy_o
);

// ===== tb/host_spi_model.sv
// host controller model on the spi target port, mode 0, msb first
// assumes the bench calls send_frame; clock stands low between frames
`timescale 1ns/100ps
module host_spi_model #(
    parameter real HALF_NS = 62.5
) (
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o
);
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    task automatic send_frame(input logic [31:0] bits);
        #17;
        spi_cs_n_o = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            spi_mosi_o = bits[i];
            #(HALF_NS);
            spi_sclk_o = 1'b1;
            #(HALF_NS);
            spi_sclk_o = 1'b0;
        end
        #(HALF_NS);
        spi_cs_n_o = 1'b1;
        // released data line shows the inverse
        spi_mosi_o = ~bits[0];
        #(HALF_NS);
    endtask
endmodule

// ===== tb/port_ctl_top_tb_top.sv
// self-checking bench for the port controller core through its spi and i2c host ports
// assumes pull-ups on open-drain lines and no downstream target answering
`timescale 1ns/100ps
`include "port_ctl_consts.svh"
module port_ctl_top_tb_top;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic en_i = 1'b1;
    logic protocol_sel_i = 1'b0;
    logic h_scl = 1'b1;
    logic h_sda = 1'b1;
    logic spi_sclk, spi_cs_n, spi_mosi, host_sda_o, host_sda_oe_o;
    logic ds_scl_o, ds_scl_oe_o, ds_sda_o, ds_sda_oe_o, host_is_i2c_o, ds_busy_o, ds_nack_o;
    logic [3:0] led_c_o, led_c_oe_o, led_d_o, led_d_oe_o;
    int bad_count = 0;
    int comparisons = 0;

    always #25 mclk_i = ~mclk_i;

    port_ctl_top i_port_ctl_top (
        .mclk_i, .rst_i, .en_i, .protocol_sel_i,
        .spi_sclk_i(spi_sclk), .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi),
        .host_scl_i(h_scl), .host_sda_i(h_sda & ~host_sda_oe_o), .host_sda_o, .host_sda_oe_o,
        .led_c_o, .led_c_oe_o, .led_d_o, .led_d_oe_o,
        .ds_scl_i(~ds_scl_oe_o), .ds_scl_o, .ds_scl_oe_o,
        .ds_sda_i(~ds_sda_oe_o), .ds_sda_o, .ds_sda_oe_o,
        .host_is_i2c_o, .ds_busy_o, .ds_nack_o
    );
    host_spi_model i_host_spi_model (.spi_sclk_o(spi_sclk), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi));

    task automatic check_vec(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_range(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset(input logic sel);
        rst_i = 1'b1;
        protocol_sel_i = sel;
        repeat (10) @(negedge mclk_i);
        check_vec(led_c_oe_o | led_d_oe_o, 4'h0);
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        check_vec(led_c_oe_o & led_d_oe_o & led_c_o & led_d_o, 4'hf);
        check_vec({3'h0, host_is_i2c_o}, {3'h0, sel});
        check_vec({1'b0, host_sda_o, ds_scl_o, ds_sda_o}, 4'h0);
    endtask

    task automatic t_leds();
        i_host_spi_model.send_frame({`OP_LED_C, 4'h0, 8'h05, `OP_LED_D, 4'h0, 8'h03});
        repeat (8) @(negedge mclk_i);
        check_vec(led_c_o, 4'ha);
        check_vec(led_d_o, 4'hc);
        i_host_spi_model.send_frame({`OP_LED_C, 4'h0, 8'h0f, `OP_LED_D, 4'h0, 8'h00});
        repeat (8) @(negedge mclk_i);
        check_vec(led_c_o, 4'h0);
        check_vec(led_d_o, 4'hf);
    endtask

    task automatic t_enable();
        en_i = 1'b0;
        repeat (12) @(negedge mclk_i);
        check_vec(led_c_oe_o | led_d_oe_o, 4'h0);
        en_i = 1'b1;
        repeat (12) @(negedge mclk_i);
        check_vec(led_c_oe_o & led_d_oe_o & led_c_o & led_d_o, 4'hf);
    endtask

    // one host byte at 1 MHz, ack checked
    task automatic i2c_byte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--) begin
            h_scl = 1'b0;
            repeat (5) @(negedge mclk_i);
            h_sda = (i == 0) ? 1'b1 : b[i-1];
            repeat (5) @(negedge mclk_i);
            h_scl = 1'b1;
            repeat (10) @(negedge mclk_i);
        end
        check_vec({3'h0, host_sda_oe_o}, 4'h1);
    endtask

    // led command through the i2c port
    task automatic t_i2c();
        h_sda = 1'b0;
        repeat (10) @(negedge mclk_i);
        i2c_byte(8'h54);
        i2c_byte({`OP_LED_C, 4'h0});
        i2c_byte(8'h06);
        h_scl = 1'b0;
        repeat (5) @(negedge mclk_i);
        h_sda = 1'b0;
        repeat (5) @(negedge mclk_i);
        h_scl = 1'b1;
        repeat (10) @(negedge mclk_i);
        h_sda = 1'b1;
        repeat (10) @(negedge mclk_i);
        check_vec(led_c_o, 4'h9);
    endtask

    task automatic t_strap();
        protocol_sel_i = 1'b1;
        repeat (20) @(negedge mclk_i);
        check_vec({3'h0, host_is_i2c_o}, 4'h0);
        do_reset(1'b1);
        i_host_spi_model.send_frame({`OP_LED_C, 4'h0, 8'h0f, `OP_LED_D, 4'h0, 8'h0f});
        repeat (8) @(negedge mclk_i);
        check_vec(led_c_o & led_d_o, 4'hf);
        t_i2c();
        do_reset(1'b0);
    endtask

    task automatic wait_scl_fall(output int n);
        logic prev;
        n = 0;
        prev = ds_scl_oe_o;
        while (n < 2000 && !(ds_scl_oe_o && !prev)) begin
            prev = ds_scl_oe_o;
            @(negedge mclk_i);
            n++;
        end
    endtask

    task automatic t_ds(input logic [3:0] flags, input int lo, input int hi);
        int n;
        int t;
        i_host_spi_model.send_frame({`OP_DS_WR, flags, 8'ha5, 16'h0000});
        for (t = 0; t < 50 && !ds_busy_o; t++) @(negedge mclk_i);
        check_vec({3'h0, ds_busy_o}, 4'h1);
        wait_scl_fall(n);
        wait_scl_fall(n);
        check_range(n, lo, hi);
        for (t = 0; t < 20000 && ds_busy_o; t++) @(negedge mclk_i);
        check_vec({3'h0, ds_busy_o}, 4'h0);
        check_vec({1'b0, ds_nack_o, ds_scl_oe_o, ds_sda_oe_o}, {2'h1, ~flags[1], 1'b0});
    endtask

    initial begin
        repeat (40000) @(posedge mclk_i);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        do_reset(1'b0);
        t_leds();
        t_enable();
        t_strap();
        t_ds(4'h3, 200, 303);
        t_ds(4'h4, 50, 75);
        t_ds(4'h7, 50, 75);
        conclude();
    end
endmodule
